// file: sim/dce_exec_tb_top.sv
// Self-checking bench for the disk command executor.
`timescale 1ns/10ps
module dce_exec_tb_top;
    import dce_pkg::*;
    logic mclk, rstn, wr, rd, intrq, is_second, second_present, pdiag_line;
    logic pdiag_n_out, pdiag_n_oe, in_standby, media_start, media_flush;
    logic media_done, media_error, slave_go;
    logic [2:0] addr;
    logic [15:0] wdata, rdata, id_rom_word, slave_delay, rd_val;
    logic [7:0] self_test_code, id_index;
    logic [23:0] media_track;
    int err_count = 0;
    int checked = 0;
    dce_exec #(.SLAVE_ASSERT_CNT(50), .MASTER_WAIT_CNT(60)) u_dut (
        .mclk(mclk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .intrq(intrq), .is_second(is_second),
        .second_present(second_present), .pdiag_n_in(pdiag_line),
        .pdiag_n_out(pdiag_n_out), .pdiag_n_oe(pdiag_n_oe),
        .in_standby(in_standby), .self_test_code(self_test_code),
        .media_start(media_start), .media_flush(media_flush),
        .media_track(media_track), .media_done(media_done),
        .media_error(media_error),
        .id_rom_word(id_rom_word), .id_index(id_index));
    dce_far_model u_far (
        .mclk(mclk), .rstn(rstn), .slave_go(slave_go),
        .slave_delay(slave_delay), .pdiag_n_out(pdiag_n_out),
        .pdiag_n_oe(pdiag_n_oe), .pdiag_line(pdiag_line),
        .media_start(media_start), .media_flush(media_flush),
        .media_done(media_done), .media_error(media_error),
        .id_index(id_index), .id_rom_word(id_rom_word));
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    task automatic print_verdict;
        if (err_count == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus_wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge mclk);
        {addr, wdata, wr} <= {a, d, 1'b1};
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    // Read data are registered on the strobe and stand from the next cycle until the next read, so sample there.
    task automatic bus_rd(input logic [2:0] a);
        @(posedge mclk);
        {addr, rd} <= {a, 1'b1};
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        rd_val = rdata;
    endtask
    task automatic run_cmd(input logic [15:0] dh, input logic [7:0] c);
        bus_wr(TF_DRVHD, dh);
        bus_wr(TF_CMD, {8'h00, c});
    endtask
    task automatic wait_irq(input int n);
        int i;
        i = 0;
        while (intrq !== 1'b1 && i < n) begin
            @(posedge mclk);
            #1;
            i++;
        end
        chk(16'(intrq), 16'h0001);
    endtask
    task automatic do_reset;
        rstn <= 1'b0;
        repeat (12) @(posedge mclk);
        rstn <= 1'b1;
    endtask
    task automatic t_reset;
        chk(16'({intrq, pdiag_n_out, pdiag_n_oe}), 16'h0002);
        bus_rd(TF_CMD);
        chk(rd_val & 16'h00FF, 16'(STATUS_RESET));
        bus_rd(TF_ERR);
        chk(rd_val & 16'h00FF, 16'(ERR_RESET));
    endtask
    task automatic t_power(input logic [7:0] c, input logic sb);
        in_standby <= sb;
        run_cmd(16'h00A0, c);
        wait_irq(20);
        bus_rd(TF_SECCNT);
        chk(rd_val & 16'h00FF, 16'(sb ? SC_STANDBY : SC_IDLE));
        bus_rd(TF_CMD);
        chk(16'({intrq, rd_val[ST_BSY]}), 16'h0000);
    endtask
    task automatic t_select;
        run_cmd(16'h00B0, CMD_PWR_A);
        repeat (10) @(posedge mclk);
        #1;
        chk(16'(intrq), 16'h0000);
    endtask
    task automatic t_diag(input logic [7:0] code, input logic pres,
                          input logic [15:0] dly, input logic [7:0] exp);
        {self_test_code, second_present, slave_delay} <= {code, pres, dly};
        run_cmd(16'h00B0, CMD_DIAG);
        slave_go <= pres;
        wait_irq(100);
        bus_wr(TF_DRVHD, 16'h00A0);
        bus_rd(TF_ERR);
        chk(rd_val & 16'h00FF, 16'(exp));
        bus_rd(TF_CMD);
        chk(16'(intrq), 16'h0000);
        slave_go <= 1'b0;
        if (exp[7]) begin
            // Host turns to the second drive; this one must stay quiet.
            bus_wr(TF_DRVHD, 16'h00B0);
            bus_rd(TF_CMD);
            chk(rd_val, 16'h0000);
        end
    endtask
    task automatic t_second;
        int i;
        is_second <= 1'b1;
        run_cmd(16'h00A0, CMD_DIAG);
        for (i = 0; i < 56 && !(pdiag_n_oe && !pdiag_n_out); i++) begin
            @(posedge mclk);
            #1;
        end
        chk(16'({pdiag_n_oe, pdiag_n_out}), 16'h0002);
        is_second <= 1'b0;
        do_reset;
    endtask
    task automatic t_flush;
        run_cmd(16'h00A0, CMD_FLUSH);
        repeat (10) @(posedge mclk);
        bus_rd(TF_CMD);
        chk(16'(rd_val[ST_BSY]), 16'h0001);
        wait_irq(60);
        bus_rd(TF_CMD);
        chk(16'(rd_val[ST_BSY]), 16'h0000);
    endtask
    task automatic t_format(input logic [15:0] dh, input logic [3:0] top);
        bus_wr(TF_CYLLO, 16'h0034);
        bus_wr(TF_CYLHI, 16'h0012);
        run_cmd(dh, CMD_FMT);
        repeat (3) @(posedge mclk);
        bus_rd(TF_CMD);
        chk(16'({rd_val[ST_BSY], rd_val[ST_DRQ]}), 16'h0001);
        for (int i = 0; i < 256; i++) bus_wr(TF_DATA, 16'h0000);
        repeat (2) @(posedge mclk);
        bus_rd(TF_CMD);
        chk(16'({rd_val[ST_BSY], rd_val[ST_DRQ]}), 16'h0002);
        wait_irq(60);
        chk(media_track[19:4], 16'h1234);
        chk(16'(media_track[23:20]), 16'(top));
        bus_rd(TF_CMD);
    endtask
    // Expected table is kept apart from the model's so a slip shows up.
    function automatic logic [15:0] exp_id(input logic [7:0] i);
        case (i)
            8'h00: return 16'h045A;
            8'h2F: return 16'h8010;
            8'h35: return 16'h0007;
            8'h3B: return 16'h0110;
            8'h02: return 16'h0000;
            default: return {i, ~i};
        endcase
    endfunction
    task automatic t_ident;
        run_cmd(16'h00A0, CMD_IDENT);
        wait_irq(20);
        bus_rd(TF_CMD);
        chk(16'({rd_val[ST_BSY], rd_val[ST_DRQ]}), 16'h0001);
        for (int i = 0; i < 256; i++) begin
            bus_rd(TF_DATA);
            chk(rd_val, exp_id(8'(i)));
        end
        bus_rd(TF_CMD);
        chk(16'(rd_val[ST_DRQ]), 16'h0000);
    endtask
    initial begin
        {wr, rd, is_second, second_present, in_standby, slave_go} = '0;
        {addr, wdata, slave_delay, self_test_code, rstn} = '0;
        do_reset;
        t_reset();
        t_power(CMD_PWR_A, 1'b1);
        t_power(CMD_PWR_B, 1'b0);
        t_power(CMD_PWR_B, 1'b1);
        t_select();
        for (int c = 1; c < 6; c++) t_diag(8'(c), 1'b0, 16'h0000, 8'(c));
        t_diag(8'h01, 1'b1, 16'h0014, 8'h01 | DIAG_SLAVE_OK);
        t_diag(8'h03, 1'b1, 16'hFFFF, 8'h03 | DIAG_SLAVE_FAIL);
        t_flush();
        t_format(16'h00A0, 4'h0);
        t_format(16'h00E5, 4'h5);
        t_ident();
        t_second();
        t_reset();
        print_verdict;
    end
    // The whole sequence needs a few thousand cycles; this bounds a hang.
    initial begin
        repeat (20000) @(posedge mclk);
        err_count++;
        print_verdict;
    end
endmodule // dce_exec_tb_top

// file: sim/dce_far_model.sv
// Far-side model: second drive on the diagnostic line, media, id table.
`timescale 1ns/10ps
module dce_far_model
    import dce_pkg::*;
#(
    parameter int MEDIA_LAT = 30
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rstn,
    // Second drive control.
    input wire logic slave_go,
    input wire logic [15:0] slave_delay,
    // Diagnostic pass line.
    input wire logic pdiag_n_out,
    input wire logic pdiag_n_oe,
    output logic pdiag_line,
    // Media engine.
    input wire logic media_start,
    input wire logic media_flush,
    output logic media_done,
    output logic media_error,
    // Identification table.
    input wire logic [7:0] id_index,
    output logic [15:0] id_rom_word
);
    logic [15:0] slave_cnt;
    logic [7:0] media_cnt;
    logic slave_low;
    // The line has a pull-up, so it is high unless someone pulls it low.
    assign slave_low = slave_go && (slave_cnt >= slave_delay);
    assign pdiag_line = !(slave_low || (pdiag_n_oe && !pdiag_n_out));
    assign media_error = 1'b0;
    always_ff @(posedge mclk) begin
        slave_cnt <= (rstn && slave_go) ? slave_cnt + 16'h0001 : 16'h0000;
        media_done <= (media_cnt == 8'h01);
        if (!rstn) begin
            media_cnt <= 8'h00;
        end else if (media_start || media_flush) begin
            media_cnt <= 8'(MEDIA_LAT);
        end else if (media_cnt != 8'h00) begin
            media_cnt <= media_cnt - 8'h01;
        end
    end
    always_comb begin
        case (id_index)
            // Fixed words come back as filler, so the executor's must win.
            8'h3B: id_rom_word = 16'hFE10;
            8'h02: id_rom_word = 16'h0000;
            default: id_rom_word = {id_index, ~id_index};
        endcase
    end
endmodule // dce_far_model

// file: src/dce_exec.sv
// Command executor of a parallel disk host port.
//
// Implementation choices: the plain strobed port and the address map.
`timescale 1ns/10ps
module dce_exec
    import dce_pkg::*;
#(
    parameter longint SLAVE_ASSERT_CNT = SLAVE_ASSERT_CYC,
    parameter longint MASTER_WAIT_CNT = MASTER_WAIT_CYC
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rstn,
    // Task-file port.
    input wire logic [2:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata,
    output logic intrq,
    // Drive straps and link.
    input wire logic is_second,
    input wire logic second_present,
    input wire logic pdiag_n_in,
    output logic pdiag_n_out,
    output logic pdiag_n_oe,
    // Media engine.
    input wire logic in_standby,
    input wire logic [7:0] self_test_code,
    output logic media_start,
    output logic media_flush,
    output logic [23:0] media_track,
    input wire logic media_done,
    input wire logic media_error,
    // Identification content.
    input wire logic [15:0] id_rom_word,
    output logic [7:0] id_index
);
    typedef enum logic [2:0] {
        S_IDLE, S_DIAG, S_FLUSH, S_FMT_FILL, S_FMT_RUN, S_ID_XFER
    } dce_state_t;

    dce_state_t state_reg, state_next;
    dce_bus_t bus;
    logic [7:0] seccnt_reg, secnum_reg, cyllo_reg, cylhi_reg, drvhd_reg;
    logic [7:0] error_reg, status_reg;
    logic [8:0] fill_reg;
    logic [31:0] timer_reg;
    logic pd_meta_reg, pd_sync_reg;
    logic [15:0] id_word;
    logic selected, cmd_wr, status_rd, data_rd, last_word;
    logic [7:0] diag_code;
    logic timeout, pass_seen;

    assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
    // Bit 4 picks which of the two drives the host is addressing.
    assign selected = drvhd_reg[DH_DEV] == is_second;
    assign cmd_wr = bus.wr && bus.addr == TF_CMD && state_reg == S_IDLE;
    assign status_rd = bus.rd && bus.addr == TF_CMD && selected;
    assign data_rd = bus.rd && bus.addr == TF_DATA && selected;
    assign last_word = id_index == ID_LAST;
    assign timeout = timer_reg == 32'(MASTER_WAIT_CNT);
    assign pass_seen = !pd_sync_reg;
    assign diag_code = self_test_code | (pass_seen ?
        DIAG_SLAVE_OK : DIAG_SLAVE_FAIL);

    // Synthesised identification words override the external table; word 59 takes its low byte from it.
    always_comb begin
        id_word = id_rom_word;
        if (id_index == 8'h00) begin
            id_word = ID_W0;
        end else if (id_index == 8'h2F) begin
            id_word = ID_W47;
        end else if (id_index == 8'h35) begin
            id_word = ID_W53;
        end else if (id_index == 8'h3B) begin
            id_word = {7'h00, ID_W59_VALID[0], id_rom_word[7:0]};
        end
    end

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            S_IDLE: begin
                if (cmd_wr && (selected || wdata[7:0] == CMD_DIAG)) begin
                    case (wdata[7:0])
                        CMD_DIAG: state_next = S_DIAG;
                        CMD_FLUSH: state_next = S_FLUSH;
                        CMD_FMT: state_next = S_FMT_FILL;
                        CMD_IDENT: state_next = S_ID_XFER;
                        default: state_next = S_IDLE;
                    endcase
                end
            end
            S_DIAG: begin
                if (is_second || !second_present || pass_seen || timeout) begin
                    state_next = S_IDLE;
                end
            end
            S_FLUSH: begin
                if (media_done || media_error) begin
                    state_next = S_IDLE;
                end
            end
            S_FMT_FILL: begin
                if (fill_reg == SECTOR_WORDS) begin
                    state_next = S_FMT_RUN;
                end
            end
            S_FMT_RUN: begin
                if (media_done || media_error) begin
                    state_next = S_IDLE;
                end
            end
            S_ID_XFER: begin
                if (data_rd && last_word) begin
                    state_next = S_IDLE;
                end
            end
            default: state_next = S_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            pd_meta_reg <= 1'b1;
            pd_sync_reg <= 1'b1;
        end else begin
            pd_meta_reg <= pdiag_n_in;
            pd_sync_reg <= pd_meta_reg;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            state_reg <= S_IDLE;
            seccnt_reg <= 8'h01;
            secnum_reg <= 8'h01;
            cyllo_reg <= 8'h00;
            cylhi_reg <= 8'h00;
            drvhd_reg <= 8'hA0;
            error_reg <= ERR_RESET;
            status_reg <= STATUS_RESET;
            fill_reg <= 9'h000;
            timer_reg <= 32'h00000000;
            id_index <= 8'h00;
            intrq <= 1'b0;
            rdata <= 16'h0000;
            pdiag_n_out <= 1'b1;
            pdiag_n_oe <= 1'b0;
            media_start <= 1'b0;
            media_flush <= 1'b0;
            media_track <= 24'h000000;
        end else begin
            state_reg <= state_next;
            media_start <= 1'b0;
            media_flush <= 1'b0;
            if (bus.wr && state_reg == S_IDLE) begin
                if (bus.addr == TF_SECCNT) begin
                    seccnt_reg <= wdata[7:0];
                end else if (bus.addr == TF_SECNUM) begin
                    secnum_reg <= wdata[7:0];
                end else if (bus.addr == TF_CYLLO) begin
                    cyllo_reg <= wdata[7:0];
                end else if (bus.addr == TF_CYLHI) begin
                    cylhi_reg <= wdata[7:0];
                end else if (bus.addr == TF_DRVHD) begin
                    drvhd_reg <= wdata[7:0];
                end
            end
            // Read data: busy forces status, the table is streamed on data.
            if (bus.rd) begin
                if (!selected) begin
                    rdata <= 16'h0000;
                end else if (status_reg[ST_BSY] || bus.addr == TF_CMD) begin
                    rdata <= {8'h00, status_reg};
                end else if (bus.addr == TF_DATA) begin
                    rdata <= state_reg == S_ID_XFER ? id_word : 16'h0000;
                end else if (bus.addr == TF_ERR) begin
                    rdata <= {8'h00, error_reg};
                end else if (bus.addr == TF_SECCNT) begin
                    rdata <= {8'h00, seccnt_reg};
                end else if (bus.addr == TF_SECNUM) begin
                    rdata <= {8'h00, secnum_reg};
                end else if (bus.addr == TF_CYLLO) begin
                    rdata <= {8'h00, cyllo_reg};
                end else if (bus.addr == TF_CYLHI) begin
                    rdata <= {8'h00, cylhi_reg};
                end else begin
                    rdata <= {8'h00, drvhd_reg};
                end
            end
            if (status_rd) begin
                intrq <= 1'b0;
            end
            if (cmd_wr && (selected || wdata[7:0] == CMD_DIAG)) begin
                status_reg[ST_BSY] <= 1'b1;
                status_reg[ST_ERR] <= 1'b0;
                timer_reg <= 32'h00000000;
                id_index <= 8'h00;
                fill_reg <= 9'h000;
                if (wdata[7:0] == CMD_PWR_A || wdata[7:0] == CMD_PWR_B) begin
                    // Answer is immediate, so busy is set and cleared at once.
                    seccnt_reg <= in_standby ? SC_STANDBY : SC_IDLE;
                    status_reg[ST_BSY] <= 1'b0;
                    intrq <= 1'b1;
                end else if (wdata[7:0] == CMD_FMT) begin
                    status_reg[ST_BSY] <= 1'b0;
                    status_reg[ST_DRQ] <= 1'b1;
                end else if (wdata[7:0] == CMD_FLUSH) begin
                    media_flush <= 1'b1;
                end else if (wdata[7:0] == CMD_DIAG && is_second) begin
                    // Own test is a single-cycle result, well inside 5 s.
                    pdiag_n_out <= 1'b0;
                    pdiag_n_oe <= 1'b1;
                end else if (wdata[7:0] != CMD_DIAG
                        && wdata[7:0] != CMD_IDENT) begin
                    status_reg[ST_BSY] <= 1'b0;
                    intrq <= 1'b1;
                end
            end
            if (state_reg == S_DIAG) begin
                timer_reg <= timer_reg + 32'h00000001;
                if (state_next == S_IDLE) begin
                    error_reg <= (is_second || !second_present) ?
                        self_test_code : diag_code;
                    status_reg[ST_BSY] <= 1'b0;
                    intrq <= 1'b1;
                end
            end
            if (state_reg == S_FLUSH || state_reg == S_FMT_RUN) begin
                if (state_next == S_IDLE) begin
                    status_reg[ST_BSY] <= 1'b0;
                    status_reg[ST_ERR] <= media_error;
                    intrq <= 1'b1;
                end
            end
            if (state_reg == S_FMT_FILL) begin
                if (bus.wr && bus.addr == TF_DATA) begin
                    fill_reg <= fill_reg + 9'h001;
                end
                if (state_next == S_FMT_RUN) begin
                    status_reg[ST_DRQ] <= 1'b0;
                    status_reg[ST_BSY] <= 1'b1;
                    media_start <= 1'b1;
                    // Cylinder high:low form track bits 19:4; drive/head bits 3:0 go on top in LBA mode only.
                    media_track <= {drvhd_reg[DH_LBA] ? drvhd_reg[3:0] : 4'h0,
                        cylhi_reg, cyllo_reg, 4'h0};
                end
            end
            if (state_reg == S_ID_XFER) begin
                if (status_reg[ST_BSY]) begin
                    status_reg[ST_BSY] <= 1'b0;
                    status_reg[ST_DRQ] <= 1'b1;
                    intrq <= 1'b1;
                end else if (data_rd) begin
                    id_index <= id_index + 8'h01;
                    if (last_word) begin
                        status_reg[ST_DRQ] <= 1'b0;
                    end
                end
            end
        end
    end

    // Command-path checks; multi-step replies are built from sequences.
    sequence s_power_cmd;
        cmd_wr && selected
            && (wdata[7:0] == CMD_PWR_A || wdata[7:0] == CMD_PWR_B);
    endsequence
    sequence s_ident_cmd;
        cmd_wr && selected && wdata[7:0] == CMD_IDENT;
    endsequence
    sequence s_ident_ready;
        !status_reg[ST_BSY] && status_reg[ST_DRQ] && intrq;
    endsequence
    property p_power_reply;
        @(posedge mclk) disable iff (!rstn)
        s_power_cmd |=> intrq && !status_reg[ST_BSY]
            && seccnt_reg == ($past(in_standby) ? SC_STANDBY : SC_IDLE);
    endproperty
    a_power_reply: assert property (p_power_reply)
        else $error("power query reply wrong");
    property p_second_pdiag;
        @(posedge mclk) disable iff (!rstn)
        cmd_wr && is_second && wdata[7:0] == CMD_DIAG
            |=> pdiag_n_oe && !pdiag_n_out;
    endproperty
    a_second_pdiag: assert property (p_second_pdiag)
        else $error("second drive did not pull the pass line");
    property p_diag_bound;
        @(posedge mclk) disable iff (!rstn)
        state_reg == S_DIAG |-> timer_reg <= 32'(MASTER_WAIT_CNT);
    endproperty
    a_diag_bound: assert property (p_diag_bound)
        else $error("diagnostic wait ran past its limit");
    property p_diag_fail;
        @(posedge mclk) disable iff (!rstn)
        state_reg == S_DIAG && !is_second && second_present && timeout
            && !pass_seen
            |=> error_reg == ($past(self_test_code) | DIAG_SLAVE_FAIL);
    endproperty
    a_diag_fail: assert property (p_diag_fail)
        else $error("silent second drive not flagged");
    property p_flush_busy;
        @(posedge mclk) disable iff (!rstn)
        state_reg == S_FLUSH |-> status_reg[ST_BSY];
    endproperty
    a_flush_busy: assert property (p_flush_busy)
        else $error("busy dropped during flush");
    property p_fmt_full;
        @(posedge mclk) disable iff (!rstn)
        state_reg == S_FMT_FILL && fill_reg == SECTOR_WORDS
            |=> status_reg[ST_BSY] && !status_reg[ST_DRQ] && media_start;
    endproperty
    a_fmt_full: assert property (p_fmt_full)
        else $error("format did not start on a full buffer");
    property p_ident_start;
        @(posedge mclk) disable iff (!rstn)
        s_ident_cmd |=> status_reg[ST_BSY] ##1 s_ident_ready;
    endproperty
    a_ident_start: assert property (p_ident_start)
        else $error("identify start sequence wrong");
    property p_ident_word0;
        @(posedge mclk) disable iff (!rstn)
        state_reg == S_ID_XFER && id_index == 8'h00 && data_rd
            && !status_reg[ST_BSY] |=> rdata == ID_W0;
    endproperty
    a_ident_word0: assert property (p_ident_word0)
        else $error("identify word 0 wrong");
    property p_ident_last;
        @(posedge mclk) disable iff (!rstn)
        state_reg == S_ID_XFER && !status_reg[ST_BSY] && data_rd
            && last_word |=> state_reg == S_IDLE && !status_reg[ST_DRQ];
    endproperty
    a_ident_last: assert property (p_ident_last)
        else $error("request not dropped after last word");
    property p_status_clear;
        @(posedge mclk) disable iff (!rstn)
        status_rd && state_reg == S_IDLE && !cmd_wr |=> !intrq;
    endproperty
    a_status_clear: assert property (p_status_clear)
        else $error("status read left interrupt pending");
endmodule // dce_exec

// file: src/dce_pkg.sv
// Package with constants and types for the disk command executor.
package dce_pkg;
    // Task-file register offsets (low three address bits).
    localparam logic [2:0] TF_DATA = 3'h0;
    localparam logic [2:0] TF_ERR = 3'h1;
    localparam logic [2:0] TF_SECCNT = 3'h2;
    localparam logic [2:0] TF_SECNUM = 3'h3;
    localparam logic [2:0] TF_CYLLO = 3'h4;
    localparam logic [2:0] TF_CYLHI = 3'h5;
    localparam logic [2:0] TF_DRVHD = 3'h6;
    localparam logic [2:0] TF_CMD = 3'h7;
    // Command codes.
    localparam logic [7:0] CMD_PWR_A = 8'h98;
    localparam logic [7:0] CMD_PWR_B = 8'hE5;
    localparam logic [7:0] CMD_DIAG = 8'h90;
    localparam logic [7:0] CMD_FLUSH = 8'hE7;
    localparam logic [7:0] CMD_FMT = 8'h50;
    localparam logic [7:0] CMD_IDENT = 8'hEC;
    // Field positions.
    localparam int DH_DEV = 4;
    localparam int DH_LBA = 6;
    localparam int ST_BSY = 7;
    localparam int ST_DRDY = 6;
    localparam int ST_DSC = 4;
    localparam int ST_DRQ = 3;
    localparam int ST_ERR = 0;
    // Values posted by commands and loaded by reset.
    localparam logic [7:0] SC_STANDBY = 8'h00;
    localparam logic [7:0] SC_IDLE = 8'hFF;
    localparam logic [7:0] DIAG_SLAVE_FAIL = 8'h80;
    localparam logic [7:0] DIAG_SLAVE_OK = 8'h00;
    localparam logic [7:0] DIAG_NO_ERROR = 8'h01;
    localparam logic [7:0] ERR_RESET = 8'h01;
    localparam logic [7:0] STATUS_RESET = 8'h50;
    // Identification words.
    localparam logic [7:0] ID_LAST = 8'hFF;
    localparam logic [15:0] ID_W0 = 16'h045A;
    localparam logic [15:0] ID_W47 = 16'h8010;
    localparam logic [15:0] ID_W53 = 16'h0007;
    localparam logic [7:0] ID_W59_VALID = 8'h01;
    localparam logic [8:0] SECTOR_WORDS = 9'h100;
    // Timing.
    localparam longint CLK_HZ = 40000000;
    localparam longint SLAVE_ASSERT_S = 5;
    localparam longint MASTER_WAIT_S = 6;
    localparam longint SLAVE_ASSERT_CYC = SLAVE_ASSERT_S * CLK_HZ;
    localparam longint MASTER_WAIT_CYC = MASTER_WAIT_S * CLK_HZ;
    // Register bus request.
    typedef struct packed {
        logic [2:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } dce_bus_t;
endpackage
